// ==== core/wd_pkg.sv ====
// Shared constants and types of the watchdog block
package wd_pkg;
    // Register offsets on the host register port
    localparam logic [7:0]  OFF_RELOAD  = 8'h00;
    localparam logic [7:0]  OFF_CTRL    = 8'h04;
    localparam logic [7:0]  OFF_KICK    = 8'h08;
    localparam logic [7:0]  OFF_COUNT   = 8'h0C;
    // Control field positions
    localparam int          BIT_EN      = 0;
    localparam int          BIT_TEST    = 1;
    localparam int          BIT_SLEEP   = 2;
    localparam int          BIT_WEEK    = 3;
    localparam int          BIT_DBG     = 4;
    localparam int          CTRL_W      = 5;
    localparam int          CNT_W       = 16;
    // Writable control bits: enable and the three stall enables
    localparam logic [4:0]  CTRL_WMASK  = 5'h1D;
    localparam logic [4:0]  CTRL_RST    = 5'h00;
    localparam logic [15:0] RELOAD_RST  = 16'hFFFF;
    localparam logic [15:0] COUNT_RST   = 16'hFFFF;
    localparam logic [15:0] COUNT_ZERO  = 16'h0000;
    localparam logic [15:0] COUNT_ONE   = 16'h0001;
    localparam logic [31:0] RD_ZERO     = 32'h0000_0000;
    // Slow clock periods per count step
    localparam int          TICKS_PER_STEP = 33;
    localparam logic [5:0]  PRESC_LAST  = 6'(TICKS_PER_STEP - 1);
    localparam logic [5:0]  PRESC_RST   = 6'h00;
    localparam logic [5:0]  PRESC_ONE   = 6'h01;
    // Run states, Gray coded along OFF -> RUN -> STALL
    typedef enum logic [1:0] {
        WD_OFF   = 2'b00,
        WD_RUN   = 2'b01,
        WD_STALL = 2'b11
    } wd_state_t;
endpackage

// ==== core/wd_step_if.sv ====
// Carrier between the slow clock sampler, prescaler and watchdog core
`timescale 1ns/1ps
interface wd_step_if;
    logic tick;   // One cycle per slow clock rising edge
    logic run;    // Counting allowed
    logic clr;    // Restart the prescaler
    logic step;   // One cycle per 33 slow ticks
    modport src   (output tick);
    modport presc (input tick, input run, input clr, output step);
    modport ctrl  (input step, output run, output clr);
endinterface

// ==== core/wd_tick.sv ====
// Slow clock edge detector giving one tick per 32 kHz period
`timescale 1ns/1ps
module wd_tick (
    input  wire logic clock_i,
    input  wire logic rst_i,
    input  wire logic slow_clk_i,
    wd_step_if.src    st
);
    logic prev_reg;
    logic prev_next;
    logic tick_reg;
    logic tick_next;

    // Rising edge of the slow clock; input already synchronous
    always_comb
    begin
        prev_next = slow_clk_i;
        tick_next = slow_clk_i & ~prev_reg; // RQ3
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            prev_reg <= 1'b1; // High, so a clock already high at release gives no false tick
            tick_reg <= 1'b0;
        end
        else
        begin
            prev_reg <= prev_next;
            tick_reg <= tick_next;
        end
    end

    assign st.tick = tick_reg;
endmodule

// ==== core/wd_presc.sv ====
// Divider giving one count step per 33 slow clock periods
`timescale 1ns/1ps
module wd_presc (
    input  wire logic clock_i,
    input  wire logic rst_i,
    wd_step_if.presc  st
);
    logic [5:0] presc_reg;
    logic [5:0] presc_next;
    logic       step_reg;
    logic       step_next;

    // Held at zero while stopped so a restart gives a full period
    always_comb
    begin
        presc_next = presc_reg;
        step_next  = 1'b0;
        if (st.clr || !st.run)
        begin
            presc_next = wd_pkg::PRESC_RST; // RQ8
        end
        else if (st.tick)
        begin
            if (presc_reg == wd_pkg::PRESC_LAST)
            begin
                presc_next = wd_pkg::PRESC_RST; // RQ11
                step_next  = 1'b1;
            end
            else
            begin
                presc_next = 6'(presc_reg + wd_pkg::PRESC_ONE);
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            presc_reg <= wd_pkg::PRESC_RST;
            step_reg  <= 1'b0;
        end
        else
        begin
            presc_reg <= presc_next;
            step_reg  <= step_next;
        end
    end

    assign st.step = step_reg;

    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);

    a_step_after_last: assert property ( // RQ11
        st.step |-> $past(presc_reg) == wd_pkg::PRESC_LAST && $past(st.tick))
        else $error("step without 33 ticks");
endmodule

// ==== core/wd_top.sv ====
// Watchdog core: registers, run control, countdown and expiry
`timescale 1ns/1ps
// Summary of operation
// [RQ1] While enabled, a missed reload before the interval ends raises expiry.
// [RQ2] Register accesses run on the host clock with no slow clock wait.
// [RQ3] Countdown logic advances only on 32 kHz clock periods.
// [RQ4] System reset returns all registers and logic to defaults; the code keeps the expiry flag, cleared only by system_reset_excl_expiry_i.
// [RQ5] Bits surviving expiry are cleared only by the expiry-excluding reset.
// [RQ6] Expiry gives a one-cycle pulse that resets the controller subsystem.
// [RQ7] Firmware loads the count, then sets enable; enable starts counting.
// [RQ8] Clearing enable stops counting and parks the divider.
// [RQ9] Underflow raises expiry and flags the external reset status bit.
// [RQ10] Counter reloads on load write, enabled kick write, or expiry.
// [RQ11] Count drops by one per 33 slow periods, down to zero.
// [RQ12] Enabled stall inputs freeze the count; release resumes from held value.
// [RQ13] Control bit 4 stalls counting while debug is active.
// [RQ14] Control bit 3 stalls counting while the week timer is active.
// [RQ15] Control bit 2 stalls counting while sleep timer 0 is active.
// [RQ16] Bit 0 enable resets 0; bit 1 reads 0; bits 7:5 reserved.
// [RQ17] Reload register is 16-bit RW, default FFFFh; writes reload counter.
// [RQ18] Kick register is a stateless write strobe; reads return zero.
// [RQ19] Enabled kick write reloads counter from reload value, keeps counting.
// [RQ20] Kick writes are ignored while enable is 0.
// [RQ21] Count register reads current count, FFFFh after system reset.
// [RQ22] Host writes reach the counting logic without lost or doubled strobes.
module wd_top (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic        system_reset_excl_expiry_i,
    input  wire logic        slow_clk_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        dbg_active_i,
    input  wire logic        week_active_i,
    input  wire logic        sleep_active_i,
    output logic      [31:0] reg_rdata_o,
    output logic             expiry_pulse_o,
    output logic             expired_flag_o
);
    wd_step_if st ();

    logic [15:0]       reload_reg;
    logic [15:0]       reload_next;
    logic [4:0]        ctrl_reg;
    logic [4:0]        ctrl_next;
    logic [15:0]       count_reg;
    logic [15:0]       count_next;
    logic [31:0]       rdata_reg;
    logic [31:0]       rdata_next;
    logic              pulse_reg;
    logic              pulse_next;
    logic              flag_reg;
    logic              flag_next;
    wd_pkg::wd_state_t state_reg;
    wd_pkg::wd_state_t state_next;
    logic              wr_reload;
    logic              wr_ctrl;
    logic              wr_kick;
    logic              dog_enable;
    logic              stall;
    logic              reload_evt;

    // Address match for one register
    function automatic logic reg_hit(input logic [7:0] addr,
                                     input logic [7:0] off);
        reg_hit = (addr == off);
    endfunction

    // Read view of the control register; test and reserved bits read 0
    function automatic logic [31:0] ctrl_view(input logic [4:0] c);
        ctrl_view = 32'(c & wd_pkg::CTRL_WMASK);
    endfunction

    wd_tick u_tick (
        .clock_i    (clock_i),
        .rst_i      (rst_i),
        .slow_clk_i (slow_clk_i),
        .st         (st.src)
    );

    wd_presc u_presc (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .st      (st.presc)
    );

    // Write strobes, decoded in the host clock cycle of the access
    assign wr_reload  = reg_wr_i & reg_hit(reg_addr_i, wd_pkg::OFF_RELOAD);
    assign wr_ctrl    = reg_wr_i & reg_hit(reg_addr_i, wd_pkg::OFF_CTRL);
    assign wr_kick    = reg_wr_i & reg_hit(reg_addr_i, wd_pkg::OFF_KICK);
    assign dog_enable = ctrl_reg[wd_pkg::BIT_EN];

    // Stall sources, each gated by its own enable
    assign stall = (ctrl_reg[wd_pkg::BIT_DBG]   & dbg_active_i)   // RQ13
                 | (ctrl_reg[wd_pkg::BIT_WEEK]  & week_active_i)  // RQ14
                 | (ctrl_reg[wd_pkg::BIT_SLEEP] & sleep_active_i); // RQ15

    // Any reload restarts the divider so the next interval is whole
    assign reload_evt = wr_reload | (wr_kick & dog_enable) | pulse_next; // RQ20
    // Enable gates counting at once, so a cleared enable never lets one more step in
    assign st.run = (state_reg == wd_pkg::WD_RUN) & dog_enable; // RQ8
    assign st.clr = reload_evt; // RQ22

    // Run state: off, counting, or stalled
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            wd_pkg::WD_OFF:
            begin
                if (dog_enable)
                begin
                    state_next = stall ? wd_pkg::WD_STALL : wd_pkg::WD_RUN; // RQ7
                end
            end
            wd_pkg::WD_RUN:
            begin
                if (!dog_enable)
                begin
                    state_next = wd_pkg::WD_OFF; // RQ8
                end
                else if (stall)
                begin
                    state_next = wd_pkg::WD_STALL; // RQ12
                end
            end
            wd_pkg::WD_STALL:
            begin
                if (!dog_enable)
                begin
                    state_next = wd_pkg::WD_OFF;
                end
                else if (!stall)
                begin
                    state_next = wd_pkg::WD_RUN; // RQ12
                end
            end
            default:
            begin
                state_next = wd_pkg::WD_OFF;
            end
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            state_reg <= wd_pkg::WD_OFF; // RQ4
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Host registers: writes take effect at the access edge
    always_comb
    begin
        reload_next = reload_reg;
        ctrl_next   = ctrl_reg;
        if (wr_reload)
        begin
            reload_next = reg_wdata_i[15:0]; // RQ17
        end
        if (wr_ctrl)
        begin
            ctrl_next = reg_wdata_i[4:0] & wd_pkg::CTRL_WMASK; // RQ16
        end
    end

    // Read data is registered, answered on the edge after the request
    always_comb
    begin
        rdata_next = wd_pkg::RD_ZERO;
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                wd_pkg::OFF_RELOAD: rdata_next = 32'(reload_reg);
                wd_pkg::OFF_CTRL:   rdata_next = ctrl_view(ctrl_reg); // RQ16
                wd_pkg::OFF_KICK:   rdata_next = wd_pkg::RD_ZERO;     // RQ18
                wd_pkg::OFF_COUNT:  rdata_next = 32'(count_reg);      // RQ21
                default:            rdata_next = wd_pkg::RD_ZERO;
            endcase
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            reload_reg <= wd_pkg::RELOAD_RST; // RQ4
            ctrl_reg   <= wd_pkg::CTRL_RST;
            rdata_reg  <= wd_pkg::RD_ZERO;
        end
        else
        begin
            reload_reg <= reload_next; // RQ2
            ctrl_reg   <= ctrl_next;
            rdata_reg  <= rdata_next;
        end
    end

    // Countdown: host reloads win over a step in the same cycle
    always_comb
    begin
        count_next = count_reg;
        pulse_next = 1'b0;
        if (wr_reload)
        begin
            count_next = reg_wdata_i[15:0]; // RQ10
        end
        else if (wr_kick && dog_enable)
        begin
            count_next = reload_reg; // RQ19
        end
        else if (st.step && st.run)
        begin
            if (count_reg == wd_pkg::COUNT_ZERO)
            begin
                count_next = reload_reg; // RQ10
                pulse_next = 1'b1;       // RQ1
            end
            else
            begin
                count_next = 16'(count_reg - wd_pkg::COUNT_ONE); // RQ11
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            count_reg <= wd_pkg::COUNT_RST; // RQ21
            pulse_reg <= 1'b0;              // RQ6
        end
        else
        begin
            count_reg <= count_next;
            pulse_reg <= pulse_next; // RQ6
        end
    end

    // Expiry status survives the system reset that expiry itself causes
    always_comb
    begin
        flag_next = flag_reg | pulse_next; // RQ9
    end

    always_ff @(posedge clock_i)
    begin
        if (system_reset_excl_expiry_i)
        begin
            flag_reg <= 1'b0; // RQ5
        end
        else
        begin
            flag_reg <= flag_next;
        end
    end

    assign reg_rdata_o    = rdata_reg;
    assign expiry_pulse_o = pulse_reg;
    assign expired_flag_o = flag_reg;

    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);

    a_load_reloads_count: assert property ( // RQ17
        wr_reload |=> count_reg == $past(reg_wdata_i[15:0])
                   && reload_reg == $past(reg_wdata_i[15:0]))
        else $error("reload write did not load counter");
    a_kick_reloads_count: assert property ( // RQ19
        wr_kick && dog_enable |=> count_reg == $past(reload_reg))
        else $error("kick did not reload counter");
    a_kick_ignored_off: assert property ( // RQ20
        wr_kick && !dog_enable |=> $stable(count_reg))
        else $error("kick changed count while disabled");
    a_off_count_frozen: assert property ( // RQ8
        state_reg == wd_pkg::WD_OFF && !wr_reload |=> $stable(count_reg))
        else $error("count moved while disabled");
    a_stall_count_frozen: assert property ( // RQ12
        state_reg == wd_pkg::WD_STALL && !reg_wr_i |=> $stable(count_reg))
        else $error("count moved while stalled");
    a_step_decrements: assert property ( // RQ11
        st.step && st.run && !reg_wr_i && count_reg != wd_pkg::COUNT_ZERO
        |=> count_reg == 16'($past(count_reg) - wd_pkg::COUNT_ONE))
        else $error("step did not decrement by one");
    a_underflow_expires: assert property ( // RQ1
        st.step && st.run && !reg_wr_i && count_reg == wd_pkg::COUNT_ZERO
        |=> expiry_pulse_o && count_reg == $past(reload_reg))
        else $error("underflow without expiry");
    a_pulse_one_cycle: assert property ( // RQ6
        expiry_pulse_o |=> !expiry_pulse_o)
        else $error("expiry pulse longer than one cycle");
    a_flag_follows_expiry: assert property ( // RQ9
        expiry_pulse_o |-> expired_flag_o)
        else $error("expiry without status flag");
    a_kick_reads_zero: assert property ( // RQ18
        reg_rd_i && reg_addr_i == wd_pkg::OFF_KICK |=> reg_rdata_o == wd_pkg::RD_ZERO)
        else $error("kick read not zero");
    a_test_bit_zero: assert property ( // RQ16
        reg_rd_i && reg_addr_i == wd_pkg::OFF_CTRL |=> reg_rdata_o[wd_pkg::BIT_TEST] == 1'b0)
        else $error("test bit read nonzero");
    a_stall_gated_run: assert property ( // RQ13
        dog_enable && stall && state_reg != wd_pkg::WD_OFF |=> !st.run)
        else $error("counting while an enabled stall is active");
    a_reset_defaults: assert property ( // RQ4
        disable iff (1'b0)
        rst_i |=> count_reg == wd_pkg::COUNT_RST && ctrl_reg == wd_pkg::CTRL_RST
               && !expiry_pulse_o)
        else $error("registers not at defaults after reset");

    // Read port and run control checks
    a_rdata_idle_zero: assert property ( // RQ2
        !reg_rd_i |=> reg_rdata_o == wd_pkg::RD_ZERO)
        else $error("read data not zero without a read");
    a_count_read_back: assert property ( // RQ21
        reg_rd_i && reg_addr_i == wd_pkg::OFF_COUNT
        |=> reg_rdata_o == 32'($past(count_reg)))
        else $error("count read differs from counter");
    a_reload_read_back: assert property ( // RQ17
        reg_rd_i && reg_addr_i == wd_pkg::OFF_RELOAD
        |=> reg_rdata_o == 32'($past(reload_reg)))
        else $error("reload read differs from register");
    a_ctrl_write_masked: assert property ( // RQ16
        wr_ctrl |=> ctrl_reg == (5'($past(reg_wdata_i)) & wd_pkg::CTRL_WMASK))
        else $error("control write not masked");
    a_enable_starts_run: assert property ( // RQ7
        state_reg == wd_pkg::WD_OFF && dog_enable && !stall |=> state_reg == wd_pkg::WD_RUN)
        else $error("enable did not start counting");
    a_disable_stops_run: assert property ( // RQ8
        !dog_enable |=> state_reg == wd_pkg::WD_OFF)
        else $error("state not off after enable cleared");
    a_stall_release_runs: assert property ( // RQ12
        state_reg == wd_pkg::WD_STALL && dog_enable && !stall |=> state_reg == wd_pkg::WD_RUN)
        else $error("count did not resume after stall release");
    a_no_pulse_stalled: assert property ( // RQ12
        !st.run |=> !expiry_pulse_o)
        else $error("expiry while not counting");

    c_expiry: cover property (expiry_pulse_o);
    c_kick_on: cover property (wr_kick && dog_enable);
    c_stall_resume: cover property (state_reg == wd_pkg::WD_STALL ##1 state_reg == wd_pkg::WD_RUN);
    c_load_then_enable: cover property (wr_reload ##[1:20] wr_ctrl && reg_wdata_i[wd_pkg::BIT_EN]);
    c_kick_ignored: cover property (wr_kick && !dog_enable);
endmodule

// ==== verification/wd_ec_model.sv ====
// Model of the controller side: slow clock source and reset logic
`timescale 1ns/1ps
module wd_ec_model (
    input  wire logic clock_i,
    input  wire logic expiry_pulse_i,
    output logic      slow_clk_o,
    output logic      sys_rst_o
);
    // Stand-in slow clock of 8 host cycles, not 32 kHz, so a step costs 264 cycles
    localparam int HALF    = 4;
    localparam int RST_LEN = 4;
    int            div_cnt = 0;
    int            rst_cnt = 0;

    initial
    begin
        slow_clk_o = 1'h0;
        sys_rst_o  = 1'h0;
    end

    // Free running slow clock; each expiry is answered by a short system reset
    always @(posedge clock_i)
    begin
        div_cnt <= (div_cnt == HALF - 1) ? 0 : div_cnt + 1;
        if (div_cnt == HALF - 1)
        begin
            slow_clk_o <= ~slow_clk_o;
        end
        if (expiry_pulse_i === 1'h1)
        begin
            rst_cnt <= RST_LEN;
        end
        else if (rst_cnt > 0)
        begin
            rst_cnt <= rst_cnt - 1;
        end
        sys_rst_o <= (expiry_pulse_i === 1'h1) || (rst_cnt > 1);
    end
endmodule

// ==== verification/test_watchdog_timer.sv ====
// Self-checking testbench of the watchdog block
`timescale 1ns/1ps
module test_watchdog_timer;
    localparam int SLOW_P = 8;
    // Three count steps of 33 ticks each; phase and sync latency give the slack
    localparam int WIN_LO = 98 * SLOW_P - 2;
    localparam int WIN_HI = 99 * SLOW_P + 12;
    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] data;
    } wd_row_t;
    logic        clock_i = 1'h0;
    logic        tb_rst = 1'h1;
    logic        ec_rst;
    logic        rst_i;
    logic        excl_rst = 1'h1;
    logic        slow_clk;
    logic [7:0]  reg_addr_i = 8'h00;
    logic        reg_wr_i = 1'h0;
    logic        reg_rd_i = 1'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic [2:0]  stall_src = 3'h0;
    logic [31:0] reg_rdata_o;
    logic        expiry_pulse_o;
    logic        expired_flag_o;
    int          n_mismatch = 0;
    int          check_count = 0;
    int          n_pulse = 0;
    // Reads carry the expected value in data; the write to control enables counting
    wd_row_t     rows [12] = '{
        '{1'h0, 8'h00, 32'h0000_FFFF}, '{1'h0, 8'h04, 32'h0}, '{1'h0, 8'h0C, 32'h0000_FFFF},
        '{1'h0, 8'h08, 32'h0}, '{1'h1, 8'h00, 32'h0000_1234}, '{1'h0, 8'h00, 32'h0000_1234},
        '{1'h0, 8'h0C, 32'h0000_1234}, '{1'h1, 8'h04, 32'h0000_00FF}, '{1'h0, 8'h04, 32'h1D},
        '{1'h1, 8'h0C, 32'h0000_5555}, '{1'h0, 8'h0C, 32'h0000_1234}, '{1'h0, 8'h10, 32'h0}};

    assign rst_i = tb_rst | ec_rst;

    // Host clock, 100 MHz
    initial
    begin
        forever #5 clock_i = ~clock_i;
    end

    wd_top dut (
        .clock_i                    (clock_i),
        .rst_i                      (rst_i),
        .system_reset_excl_expiry_i (excl_rst),
        .slow_clk_i                 (slow_clk),
        .reg_addr_i                 (reg_addr_i),
        .reg_wr_i                   (reg_wr_i),
        .reg_rd_i                   (reg_rd_i),
        .reg_wdata_i                (reg_wdata_i),
        .dbg_active_i               (stall_src[2]),
        .week_active_i              (stall_src[1]),
        .sleep_active_i             (stall_src[0]),
        .reg_rdata_o                (reg_rdata_o),
        .expiry_pulse_o             (expiry_pulse_o),
        .expired_flag_o             (expired_flag_o)
    );

    wd_ec_model ec (
        .clock_i        (clock_i),
        .expiry_pulse_i (expiry_pulse_o),
        .slow_clk_o     (slow_clk),
        .sys_rst_o      (ec_rst)
    );

    // Pulses are counted so that an early expiry cannot hide between checks
    always @(posedge clock_i)
    begin
        if (expiry_pulse_o === 1'h1)
        begin
            n_pulse <= n_pulse + 1;
        end
    end

    task automatic end_sim();
        if (n_mismatch == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'h1;
        @(posedge clock_i);
        reg_wr_i    <= 1'h0;
    endtask

    task automatic read_check(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'h1;
        @(posedge clock_i);
        reg_rd_i   <= 1'h0;
        #1;
        check(what, exp, reg_rdata_o);
    endtask

    // Waits for expiry counted from the last host edge, then lets the reset pass
    task automatic wait_expiry(input string what);
        int n;
        n = 0;
        while (n <= WIN_HI && expiry_pulse_o !== 1'h1)
        begin
            @(posedge clock_i);
            #1;
            n++;
        end
        check(what, 32'h1, 32'(n >= WIN_LO && n <= WIN_HI));
        check("expired flag", 32'h1, 32'(expired_flag_o));
        @(posedge clock_i);
        #1;
        check("pulse width", 32'h0, 32'(expiry_pulse_o));
        repeat (8) @(posedge clock_i);
    endtask

    // Free-running limit well above the roughly 12,000 cycles the tests need
    initial
    begin
        repeat (60000) @(posedge clock_i);
        n_mismatch++;
        end_sim();
    end

    initial
    begin
        int        saved;
        logic [4:0] m;
        repeat (8) @(posedge clock_i);
        tb_rst   <= 1'h0;
        excl_rst <= 1'h0;
        foreach (rows[i])
        begin
            if (rows[i].wr)
                reg_write(rows[i].addr, rows[i].data);
            else
                read_check("register", rows[i].addr, rows[i].data);
        end
        reg_write(wd_pkg::OFF_RELOAD, 32'h3);
        reg_write(wd_pkg::OFF_CTRL, 32'h1);
        repeat (350) @(posedge clock_i);
        reg_write(wd_pkg::OFF_CTRL, 32'h0);
        read_check("count after one step", wd_pkg::OFF_COUNT, 32'h2);
        reg_write(wd_pkg::OFF_KICK, 32'h0);
        read_check("count after idle kick", wd_pkg::OFF_COUNT, 32'h2);
        repeat (600) @(posedge clock_i);
        read_check("count while disabled", wd_pkg::OFF_COUNT, 32'h2);
        reg_write(wd_pkg::OFF_CTRL, 32'h1);
        wait_expiry("expiry from held count");
        read_check("control after expiry", wd_pkg::OFF_CTRL, 32'h0);
        read_check("count after expiry", wd_pkg::OFF_COUNT, 32'h0000_FFFF);
        check("flag kept over reset", 32'h1, 32'(expired_flag_o));
        excl_rst <= 1'h1;
        @(posedge clock_i);
        excl_rst <= 1'h0;
        @(posedge clock_i);
        #1;
        check("flag after own reset", 32'h0, 32'(expired_flag_o));
        // Reload by kick, then by load write, just before the count runs out
        for (int k = 0; k < 2; k++)
        begin
            reg_write(wd_pkg::OFF_RELOAD, 32'h2);
            reg_write(wd_pkg::OFF_CTRL, 32'h1);
            repeat (500) @(posedge clock_i);
            saved = n_pulse;
            reg_write((k == 0) ? wd_pkg::OFF_KICK : wd_pkg::OFF_RELOAD, 32'h2);
            check("no early expiry", 32'(saved), 32'(n_pulse));
            wait_expiry("expiry after reload");
        end
        // Each stall source, first with its enable clear, then with it set
        for (int i = 0; i < 3; i++)
        begin
            m = 5'h01 << (wd_pkg::BIT_SLEEP + i);
            stall_src <= 3'(1 << i);
            reg_write(wd_pkg::OFF_RELOAD, 32'h2);
            reg_write(wd_pkg::OFF_CTRL, 32'(5'h1D & ~m));
            wait_expiry("expiry with source unmasked");
            reg_write(wd_pkg::OFF_RELOAD, 32'h2);
            reg_write(wd_pkg::OFF_CTRL, 32'(5'h01 | m));
            repeat (1000) @(posedge clock_i);
            read_check("count while stalled", wd_pkg::OFF_COUNT, 32'h2);
            stall_src <= 3'h0;
            wait_expiry("expiry after stall release");
        end
        end_sim();
    end
endmodule
